// ### wrc_pkg.sv
// package: register map, field layout and timing constants for the reset block
package wrc_pkg;
  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [11:0] WRC_OFF_WDTCTL = 12'h000;
  localparam logic [11:0] WRC_OFF_THRESH = 12'h004;
  localparam logic [11:0] WRC_OFF_RSTSRC = 12'h008;
  localparam logic [11:0] WRC_OFF_CMD = 12'h00c;
  localparam logic [11:0] WRC_OFF_STATE = 12'h010;
  // ---------------------------------------------------------------
  // reset values and key codes
  // ---------------------------------------------------------------
  localparam logic [7:0] WRC_WDTCTL_RST = 8'h53;
  localparam logic [4:0] WRC_KEY_A = 5'h0a;
  localparam logic [4:0] WRC_KEY_B = 5'h15;
  localparam logic [7:0] WRC_THR_RST = 8'h55;
  localparam logic [7:0] WRC_THR_B = 8'h33;
  localparam logic [7:0] WRC_THR_C = 8'h99;
  localparam logic [7:0] WRC_THR_D = 8'haa;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int WRC_KEY_LSB = 3;
  localparam int WRC_BIT_LVF = 2;
  localparam int WRC_BIT_THF = 1;
  localparam int WRC_BIT_WKF = 0;
  localparam int WRC_BIT_CLR = 0;
  localparam int WRC_BIT_HALT = 1;
  localparam int WRC_BIT_SLEEP = 2;
  localparam int WRC_BIT_EXP = 3;
  localparam int WRC_KEEP_LSB = 7;
  localparam int WRC_OSC_LSB = 4;
  // ---------------------------------------------------------------
  // timing, bus response codes and sequencer states
  // ---------------------------------------------------------------
  localparam int WRC_CLK_HZ = 10_000_000;
  localparam int WRC_DEBOUNCE_TICKS = 3;
  localparam int WRC_POR_DELAY_US = 16700;
  localparam int WRC_POR_DELAY_CYC =
    (WRC_POR_DELAY_US * (WRC_CLK_HZ / 1_000_000));
  localparam int WRC_LV_MIN_NS = 1000;
  localparam int WRC_LV_MIN_CYC = (WRC_LV_MIN_NS * 10 + 999) / 1000 + 1;
  localparam int WRC_DIV_BASE = 8;
  localparam logic [1:0] WRC_RESP_OKAY = 2'b00;
  localparam logic [1:0] WRC_RESP_SLVERR = 2'b10;
  typedef enum logic [1:0] {
    WRC_RUN = 2'b00,
    WRC_HOLD = 2'b01,
    WRC_DELAY = 2'b10
  } wrc_state_e;
endpackage

// ### wrc_watchdog_reset.sv
// watchdog, key checks, low-voltage filter and reset-source flags
`timescale 1ns/100ps
`default_nettype none
module wrc_watchdog_reset
  import wrc_pkg::*;
#(
  parameter int POR_DELAY_CYC = WRC_POR_DELAY_CYC,
  parameter int LV_MIN_CYC = WRC_LV_MIN_CYC
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic slowClkPin,
  input wire logic lowVoltPin,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic coreReset,
  output logic cpuRun,
  output logic pcSpClear,
  output logic portsInput,
  output logic expiryFlag
);
  // ---------------------------------------------------------------
  // functions
  // ---------------------------------------------------------------
  function automatic logic keyValid(input logic [4:0] k);
    keyValid = (k == WRC_KEY_A) || (k == WRC_KEY_B);
  endfunction
  function automatic logic thrValid(input logic [7:0] t);
    thrValid = (t == WRC_THR_RST) || (t == WRC_THR_B) ||
               (t == WRC_THR_C) || (t == WRC_THR_D);
  endfunction
  function automatic logic [4:0] divBit(input logic [2:0] s);
    // exponent of the divide: low codes step by two, high codes by one
    case (s)
      3'h0: divBit = 5'(WRC_DIV_BASE);
      3'h1: divBit = 5'(WRC_DIV_BASE + 2);
      3'h2: divBit = 5'(WRC_DIV_BASE + 4);
      3'h3: divBit = 5'(WRC_DIV_BASE + 6);
      3'h4: divBit = 5'(WRC_DIV_BASE + 7);
      3'h5: divBit = 5'(WRC_DIV_BASE + 8);
      3'h6: divBit = 5'(WRC_DIV_BASE + 9);
      default: divBit = 5'(WRC_DIV_BASE + 10);
    endcase
  endfunction
  function automatic logic [18:0] ovfLimit(input logic [2:0] s);
    // last count before expiry, so a period is exactly 2^n ticks
    ovfLimit = (19'h1 << divBit(s)) - 19'h1;
  endfunction
  // ---------------------------------------------------------------
  // synchronisers
  // ---------------------------------------------------------------
  logic slowMeta_q, slowSync_q, slowPrev_q, lvMeta_q, lvSync_q;
  logic slowTick;
  // two stages before any logic reads either pin
  always_ff @(posedge clk) begin
    if (srst) begin
      slowMeta_q <= 1'b0;
      slowSync_q <= 1'b0;
      slowPrev_q <= 1'b0;
      lvMeta_q <= 1'b0;
      lvSync_q <= 1'b0;
    end else begin
      slowMeta_q <= slowClkPin;
      slowSync_q <= slowMeta_q;
      slowPrev_q <= slowSync_q;
      lvMeta_q <= lowVoltPin;
      lvSync_q <= lvMeta_q;
    end
  end
  // one tick per rising edge of the synced slow clock
  assign slowTick = slowSync_q & ~slowPrev_q;
  // ---------------------------------------------------------------
  // registers and state
  // ---------------------------------------------------------------
  wrc_state_e state_q;
  logic [7:0] wdtCtl_q, thr_q;
  logic [1:0] oscSel_q;
  logic keepClk_q, sleep_q;
  logic lvFlag_q, thFlag_q, wkFlag_q;
  logic [18:0] wdtCnt_q;
  logic [1:0] keyDeb_q, thrDeb_q;
  logic [31:0] lvCnt_q, delay_q;
  logic wrDone, rdDone, clrCmd, haltCmd, clrExp;
  logic wdtOvf, keyRst, thrRst, lvRst, fullRst;
  logic [31:0] wmask;
  assign wmask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                  {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
  // >= so a period shortened below the count expires on the next slow tick, not after a wrap
  assign wdtOvf = slowTick &&
                  (wdtCnt_q >= ovfLimit(wdtCtl_q[2:0]));
  assign keyRst = slowTick && (keyDeb_q == 2'(WRC_DEBOUNCE_TICKS - 1));
  assign thrRst = slowTick && (thrDeb_q == 2'(WRC_DEBOUNCE_TICKS - 1));
  assign lvRst = lvSync_q && (lvCnt_q == 32'(LV_MIN_CYC));
  // normal expiry is a full reset; sleep expiry is not
  assign fullRst = (state_q == WRC_RUN) &&
                   ((wdtOvf && !sleep_q) || keyRst || thrRst || lvRst);
  // ---------------------------------------------------------------
  // AXI4-Lite write path
  // ---------------------------------------------------------------
  logic awHeld_q, wHeld_q;
  logic [11:0] awAddr_q;
  logic [31:0] wData_q, wMask_q;
  // readies pulse for one cycle; address and data are taken independently
  always_ff @(posedge clk) begin
    if (srst) begin
      awHeld_q <= 1'b0;
      wHeld_q <= 1'b0;
      awAddr_q <= 12'h000;
      wData_q <= 32'h0;
      wMask_q <= 32'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= WRC_RESP_OKAY;
    end else begin
      s_axi_awready <= !awHeld_q && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !wHeld_q && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wMask_q <= wmask;
      end
      if (wrDone) begin
        awHeld_q <= 1'b0;
        wHeld_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (awAddr_q == WRC_OFF_WDTCTL || awAddr_q == WRC_OFF_THRESH ||
            awAddr_q == WRC_OFF_RSTSRC || awAddr_q == WRC_OFF_CMD) begin
          s_axi_bresp <= WRC_RESP_OKAY;
        end else begin
          // unmapped write: error answer, nothing changes
          s_axi_bresp <= WRC_RESP_SLVERR;
        end
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  assign wrDone = awHeld_q && wHeld_q && !s_axi_bvalid;
  assign clrCmd = wrDone && awAddr_q == WRC_OFF_CMD &&
                  wMask_q[WRC_BIT_CLR] && wData_q[WRC_BIT_CLR];
  assign haltCmd = wrDone && awAddr_q == WRC_OFF_CMD &&
                   wMask_q[WRC_BIT_HALT] && wData_q[WRC_BIT_HALT];
  assign clrExp = wrDone && awAddr_q == WRC_OFF_CMD &&
                  wMask_q[WRC_BIT_EXP] && wData_q[WRC_BIT_EXP];
  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  logic [7:0] wb;
  assign wb = (wData_q[7:0] & wMask_q[7:0]);
  always_ff @(posedge clk) begin
    if (srst || fullRst) begin
      wdtCtl_q <= WRC_WDTCTL_RST;
      thr_q <= WRC_THR_RST;
      // clock select and idle keep also fall back on a full reset
      oscSel_q <= 2'b00;
      keepClk_q <= 1'b0;
      sleep_q <= 1'b0;
    end else if (wrDone) begin
      if (awAddr_q == WRC_OFF_WDTCTL && wMask_q[0]) begin
        wdtCtl_q <= wData_q[7:0];
      end else if (awAddr_q == WRC_OFF_THRESH && wMask_q[0]) begin
        thr_q <= wData_q[7:0]; // any code accepted
      end else if (awAddr_q == WRC_OFF_RSTSRC && wMask_q[0]) begin
        oscSel_q <= wData_q[WRC_OSC_LSB +: 2];
        keepClk_q <= wData_q[WRC_KEEP_LSB];
      end else if (awAddr_q == WRC_OFF_CMD && wMask_q[0]) begin
        // halt or the sleep bit enters sleep; a CMD write with neither bit set wakes here
        sleep_q <= wData_q[WRC_BIT_SLEEP] | haltCmd;
      end
    end else if (wdtOvf && sleep_q) begin
      sleep_q <= 1'b0; // expiry wakes the core
    end
  end
  // ---------------------------------------------------------------
  // reset-source flags: set beats software clear
  // ---------------------------------------------------------------
  logic wrSrc;
  assign wrSrc = wrDone && awAddr_q == WRC_OFF_RSTSRC && wMask_q[0];
  // writing one to a flag leaves it alone; only zero clears
  always_ff @(posedge clk) begin
    if (srst) begin
      lvFlag_q <= 1'b0;
      thFlag_q <= 1'b0;
      wkFlag_q <= 1'b0;
    end else begin
      if (state_q == WRC_RUN && lvRst) begin
        lvFlag_q <= 1'b1;
      end else if (wrSrc && !wb[WRC_BIT_LVF]) begin
        lvFlag_q <= 1'b0;
      end
      if (state_q == WRC_RUN && thrRst) begin
        thFlag_q <= 1'b1;
      end else if (wrSrc && !wb[WRC_BIT_THF]) begin
        thFlag_q <= 1'b0;
      end
      if (state_q == WRC_RUN && keyRst) begin
        wkFlag_q <= 1'b1;
      end else if (wrSrc && !wb[WRC_BIT_WKF]) begin
        wkFlag_q <= 1'b0;
      end
    end
  end
  // ---------------------------------------------------------------
  // watchdog counter and debounce
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst || fullRst || clrCmd || haltCmd) begin
      wdtCnt_q <= 19'h0;
    end else if (wdtOvf) begin
      // restart the period after every expiry, asleep or not
      wdtCnt_q <= 19'h0;
    end else if (slowTick) begin
      wdtCnt_q <= wdtCnt_q + 19'h1;
    end
  end
  always_ff @(posedge clk) begin
    if (srst || fullRst || keyValid(wdtCtl_q[7:WRC_KEY_LSB])) begin
      // a good key restarts the debounce
      keyDeb_q <= 2'b00;
    end else if (slowTick) begin
      keyDeb_q <= keyDeb_q + 2'b01;
    end
  end
  always_ff @(posedge clk) begin
    if (srst || fullRst || thrValid(thr_q)) begin
      // a bad code is how software forces a reset on purpose
      thrDeb_q <= 2'b00;
    end else if (slowTick) begin
      thrDeb_q <= thrDeb_q + 2'b01;
    end
  end
  always_ff @(posedge clk) begin
    if (srst || !lvSync_q) begin
      lvCnt_q <= 32'h0; // short dips ignored
    end else if (lvCnt_q != 32'(LV_MIN_CYC)) begin
      // saturates so the request stands until the sequencer holds
      lvCnt_q <= lvCnt_q + 32'h1;
    end
  end
  // ---------------------------------------------------------------
  // reset sequencer
  // the watchdog keeps counting through the delay, from zero
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      state_q <= WRC_DELAY;
      delay_q <= 32'h0;
    end else begin
      case (state_q)
        WRC_RUN: begin
          if (fullRst) begin
            state_q <= WRC_HOLD;
          end
        end
        WRC_HOLD: begin
          if (!lvSync_q) begin
            state_q <= WRC_DELAY; // hold while supply is low
            delay_q <= 32'h0;
          end
        end
        default: begin
          if (delay_q == 32'(POR_DELAY_CYC - 1)) begin
            state_q <= WRC_RUN;
          end else begin
            delay_q <= delay_q + 32'h1;
          end
        end
      endcase
    end
  end
  // ---------------------------------------------------------------
  // core-facing outputs
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      coreReset <= 1'b1;
      portsInput <= 1'b1;
      cpuRun <= 1'b0;
      pcSpClear <= 1'b0;
      expiryFlag <= 1'b0;
    end else begin
      coreReset <= (state_q != WRC_RUN) || fullRst;
      portsInput <= (state_q != WRC_RUN) || fullRst;
      // the core stops while asleep
      cpuRun <= (state_q == WRC_RUN) && !fullRst && !sleep_q;
      pcSpClear <= (state_q == WRC_RUN) && wdtOvf && sleep_q;
      // flag survives a full reset so software can tell why it restarted
      if (state_q == WRC_RUN && wdtOvf) begin
        expiryFlag <= 1'b1;
      end else if (clrExp || clrCmd || haltCmd) begin
        expiryFlag <= 1'b0;
      end
    end
  end
  // ---------------------------------------------------------------
  // AXI4-Lite read path
  // ---------------------------------------------------------------
  assign rdDone = s_axi_arvalid && s_axi_arready;
  // rvalid and rdata stand until rready is seen
  always_ff @(posedge clk) begin
    if (srst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= WRC_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (rdDone) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= WRC_RESP_OKAY;
        if (s_axi_araddr == WRC_OFF_WDTCTL) begin
          s_axi_rdata <= {24'h0, wdtCtl_q};
        end else if (s_axi_araddr == WRC_OFF_THRESH) begin
          s_axi_rdata <= {24'h0, thr_q};
        end else if (s_axi_araddr == WRC_OFF_RSTSRC) begin
          // unimplemented bits read zero
          s_axi_rdata <= {24'h0, keepClk_q, 1'b0, oscSel_q, 1'b0,
                          lvFlag_q, thFlag_q, wkFlag_q};
        end else if (s_axi_araddr == WRC_OFF_CMD) begin
          s_axi_rdata <= {28'h0, expiryFlag, sleep_q, 2'b00};
        end else if (s_axi_araddr == WRC_OFF_STATE) begin
          s_axi_rdata <= {11'h0, wdtCnt_q, 2'(state_q)};
        end else begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= WRC_RESP_SLVERR;
        end
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ### wrc_watchdog_reset_sva.sv
// checker: port-level properties of the watchdog and reset block
`timescale 1ns/100ps
`default_nettype none
module wrc_watchdog_reset_sva #(
  parameter int POR_DELAY_CYC = 20,
  parameter int LV_MIN_CYC = 4
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic lowVoltPin,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic coreReset,
  input wire logic cpuRun,
  input wire logic pcSpClear,
  input wire logic portsInput,
  input wire logic expiryFlag
);
  // ---------------------------------------------------------------
  // helper counters
  // ---------------------------------------------------------------
  // both saturate so a long run never wraps into a false match
  logic [31:0] idleRun_q;
  logic [31:0] lvRun_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  always_ff @(posedge clk) begin
    if (srst || cpuRun) idleRun_q <= '0;
    else if (idleRun_q < 32'h00ffffff) idleRun_q <= idleRun_q + 1;
  end
  always_ff @(posedge clk) begin
    if (srst || !lowVoltPin) lvRun_q <= '0;
    else if (lvRun_q < 32'h0000ffff) lvRun_q <= lvRun_q + 1;
  end
  property p_rstState;
    $fell(srst) |-> coreReset && portsInput && !cpuRun && !expiryFlag;
  endproperty
  a_rstState: assert property (p_rstState)
    else $error("outputs not in reset state after srst");
  property p_por;
    $rose(cpuRun) |-> idleRun_q >= POR_DELAY_CYC;
  endproperty
  a_por: assert property (p_por)
    else $error("core released before power-on delay");
  property p_run;
    cpuRun |-> !coreReset;
  endproperty
  a_run: assert property (p_run)
    else $error("core runs while held in reset");
  property p_rstPorts;
    $rose(coreReset) |-> portsInput;
  endproperty
  a_rstPorts: assert property (p_rstPorts)
    else $error("ports not forced to inputs on reset");
  property p_pcsp;
    pcSpClear |-> !coreReset ##1 !pcSpClear;
  endproperty
  a_pcsp: assert property (p_pcsp)
    else $error("sleep expiry pulse wrong");
  property p_expSleep;
    $rose(pcSpClear) |-> ##[0:1] expiryFlag;
  endproperty
  a_expSleep: assert property (p_expSleep)
    else $error("expiry flag missing on sleep expiry");
  property p_lv;
    lvRun_q == LV_MIN_CYC + 6 |-> coreReset;
  endproperty
  a_lv: assert property (p_lv)
    else $error("long low voltage gave no reset");
  property p_rAns;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rAns: assert property (p_rAns)
    else $error("read answer late");
  property p_bDone;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
  endproperty
  a_bDone: assert property (p_bDone)
    else $error("write response not released");
  property p_awPulse;
    s_axi_awready |=> !s_axi_awready;
  endproperty
  a_awPulse: assert property (p_awPulse)
    else $error("awready longer than one cycle");
  c_reset: cover property ($rose(coreReset));
  c_sleep: cover property (pcSpClear);
  c_run: cover property ($rose(cpuRun));
endmodule
`default_nettype wire

// ### test_watchdog_and_reset_control.sv
// testbench: register bus, reset sources and watchdog expiry
`timescale 1ns/100ps
`default_nettype none
module test_watchdog_and_reset_control;
  import wrc_pkg::*;
  logic clk, srst, slowClkPin, lowVoltPin, coreReset, cpuRun;
  logic pcSpClear, portsInput, expiryFlag, s_axi_awvalid, s_axi_wvalid;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, v;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [2:0] div;
  logic [7:0] srcM;
  logic [7:0] codes [4];
  int n_mismatch, cmp_count, n;
  wrc_watchdog_reset #(.POR_DELAY_CYC(20), .LV_MIN_CYC(4)) uut (.*);
  initial begin
    clk = 0;
    forever #50 clk = ~clk;
  end
  // slow oscillator: one tick every eight cycles
  always @(posedge clk) begin
    div <= div + 3'h1;
    slowClkPin <= div[2];
  end
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] e);
    cmp_count++;
    if (seen !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, seen);
    end
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (s_axi_bvalid !== 1'b1);
    chk("bresp", s_axi_bresp, WRC_RESP_OKAY);
    s_axi_bready <= 0;
    @(posedge clk);
  endtask
  task rd(input logic [11:0] a, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (s_axi_rvalid !== 1'b1);
    v = s_axi_rdata;
    chk("rresp", s_axi_rresp, er);
    s_axi_rready <= 0;
    @(posedge clk);
  endtask
  task rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    rd(a, WRC_RESP_OKAY);
    chk($sformatf("reg%h", a), v & m, e);
  endtask
  task waitR(input int lim);
    n = 0;
    while (coreReset !== 1'b1 && n < lim) begin
      @(posedge clk);
      n++;
    end
  endtask
  task waitRun;
    waitR(300);
    n = 0;
    while (cpuRun !== 1'b1 && n < 300) begin
      @(posedge clk);
      n++;
    end
    chk("cpuRun", cpuRun, 1);
  endtask
  // a bad code must reset within 8 to 40 cycles, then set its flag
  task badRun(input logic [11:0] a, input logic [31:0] d, input logic [7:0] f);
    wr(a, d);
    waitR(60);
    chk("rstDelay", n inside {[8:40]}, 1);
    waitRun;
    srcM = srcM | f;
    rdc(WRC_OFF_RSTSRC, 32'hff, srcM);
    wr(WRC_OFF_RSTSRC, 32'h0);
    srcM = 0;
  endtask
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    v = $urandom(32'h579d);
    {srst, div, lowVoltPin, s_axi_awvalid, s_axi_wvalid} = '1;
    {s_axi_bready, s_axi_arvalid, s_axi_rready, slowClkPin} = '0;
    {lowVoltPin, div, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid} = '0;
    s_axi_wstrb = 4'h1;
    codes = '{WRC_THR_B, WRC_THR_C, WRC_THR_D, WRC_THR_RST};
    repeat (8) @(posedge clk);
    chk("resetPorts", {coreReset, portsInput, cpuRun}, 3'b110);
    srst <= 0;
    waitRun;
    rdc(WRC_OFF_WDTCTL, 32'hffffffff, WRC_WDTCTL_RST);
    rdc(WRC_OFF_THRESH, 32'hffffffff, WRC_THR_RST);
    rdc(WRC_OFF_RSTSRC, 32'hffffff4b, 32'h0);
    rd(12'h020, WRC_RESP_SLVERR);
    chk("unmapped", v, 0);
    wr(WRC_OFF_RSTSRC, 32'h0);
    srcM = 0;
    foreach (codes[i]) begin
      wr(WRC_OFF_THRESH, {24'h0, codes[i]});
      waitR(48);
      chk("thrOk", coreReset, 0);
      rdc(WRC_OFF_THRESH, 32'hff, codes[i]);
    end
    do v = $urandom & 32'hff;
    while (v[7:0] inside {WRC_THR_RST, WRC_THR_B, WRC_THR_C, WRC_THR_D});
    badRun(WRC_OFF_THRESH, v, 8'h02);
    rdc(WRC_OFF_THRESH, 32'hff, WRC_THR_RST);
    wr(WRC_OFF_WDTCTL, {24'h0, WRC_KEY_B, 3'h3});
    waitR(48);
    chk("keyOk", coreReset, 0);
    do v = $urandom & 32'h1f;
    while (v[4:0] inside {WRC_KEY_A, WRC_KEY_B});
    badRun(WRC_OFF_WDTCTL, {24'h0, v[4:0], 3'h3}, 8'h01);
    rdc(WRC_OFF_WDTCTL, 32'hff, WRC_WDTCTL_RST);
    lowVoltPin <= 1;
    repeat (2) @(posedge clk);
    lowVoltPin <= 0;
    waitR(30);
    chk("shortDip", coreReset, 0);
    lowVoltPin <= 1;
    waitR(30);
    chk("longDip", coreReset, 1);
    repeat (5) @(posedge clk);
    lowVoltPin <= 0;
    waitRun;
    wr(WRC_OFF_RSTSRC, 32'h04);
    rdc(WRC_OFF_RSTSRC, 32'hff, 32'h04);
    wr(WRC_OFF_RSTSRC, 32'h0);
    rdc(WRC_OFF_RSTSRC, 32'h07, 32'h0);
    wr(WRC_OFF_WDTCTL, {24'h0, WRC_KEY_A, 3'h0});
    wr(WRC_OFF_CMD, 32'h1);
    repeat (1200) @(posedge clk);
    chk("noEarly", coreReset, 0);
    wr(WRC_OFF_CMD, 32'h1);
    waitR(2300);
    chk("expiryTime", n inside {[2000:2100]}, 1);
    chk("expiryFlag", expiryFlag, 1);
    waitRun;
    rdc(WRC_OFF_WDTCTL, 32'hff, WRC_WDTCTL_RST);
    rdc(WRC_OFF_RSTSRC, 32'h7, srcM);
    wr(WRC_OFF_CMD, 32'h8);
    chk("flagClr", expiryFlag, 0);
    wr(WRC_OFF_WDTCTL, {24'h0, WRC_KEY_A, 3'h0});
    wr(WRC_OFF_CMD, 32'h2);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pcSpClear !== 1'b1 && n < 2300);
    chk("sleepTime", n inside {[2000:2100]}, 1);
    @(posedge clk);
    chk("sleepRst", {coreReset, expiryFlag}, 2'b01);
    rdc(WRC_OFF_WDTCTL, 32'hff, {WRC_KEY_A, 3'h0});
    srst <= 1;
    repeat (8) @(posedge clk);
    chk("midReset", {coreReset, portsInput, cpuRun, expiryFlag}, 4'hc);
    srst <= 0;
    waitRun;
    rdc(WRC_OFF_WDTCTL, 32'hff, WRC_WDTCTL_RST);
    give_verdict;
  end
  initial begin
    #2_000_000;
    n_mismatch++;
    give_verdict;
  end
endmodule
bind wrc_watchdog_reset wrc_watchdog_reset_sva #(
  .POR_DELAY_CYC(POR_DELAY_CYC),
  .LV_MIN_CYC(LV_MIN_CYC)
) chk (.*);
`default_nettype wire
